/* rtl/adcsp_core.sv */
// Purpose: Serial register-access engine of the converter's SPI slave port.
// Assumes: SPI modes 0,0 and 1,1; SCK is far slower than core_clk (8x or more).
// Notes:   Register contents live outside, except the conversion result held here; writes leave through a FIFO.

`timescale 1ns/1ps

module adcsp_core (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Serial pins
  input wire logic sck_pin,
  input wire logic cs_b_pin,
  input wire logic sdi_pin,
  output logic sdo_out,
  output logic sdo_oe_b,
  // Conversion and event sources
  input wire logic conv_valid,
  input wire logic [15:0] conv_data,
  input wire logic cfg_err_event,
  // Register image for reads
  input wire logic [15:0][31:0] reg_image,
  // Committed write stream
  output logic wr_valid,
  input wire logic wr_ready,
  output adcsp_pkg::adcsp_wr_word_t wr_word,
  // Status
  output logic frame_active,
  output logic [3:0] ptr_out,
  output adcsp_pkg::adcsp_flags_t flags_out,
  output logic wr_overflow
);

  // ---------------------------------------------------------------------------
  // Pin sampling and edge detection
  // ---------------------------------------------------------------------------
  logic [2:0] pins_s;
  logic sck_s;
  logic cs_b_s;
  logic sdi_s;
  logic sck_prev_q;
  logic cs_prev_q;
  logic rise;
  logic fall;
  logic cs_fall;
  logic cs_rise;

  adcsp_sync #(
    .WIDTH(3),
    .RST_VAL(3'h2)
  ) u_sync (
    .clk(core_clk),
    .rst_b(rst_b),
    .din({sck_pin, cs_b_pin, sdi_pin}),
    .dout(pins_s)
  );

  assign sck_s = pins_s[2];
  assign cs_b_s = pins_s[1];
  assign sdi_s = pins_s[0];

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sck_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
    end else begin
      sck_prev_q <= sck_s;
      cs_prev_q <= cs_b_s;
    end
  end

  assign rise = sck_s && !sck_prev_q && !cs_b_s;
  assign fall = !sck_s && sck_prev_q && !cs_b_s;
  assign cs_fall = !cs_b_s && cs_prev_q;
  assign cs_rise = cs_b_s && !cs_prev_q;

  // ---------------------------------------------------------------------------
  // Frame state
  // ---------------------------------------------------------------------------
  adcsp_pkg::adcsp_state_t st_q;
  logic [7:0] cmd_sr_q;
  logic [7:0] cmd_next;
  logic [1:0] ctype_q;
  logic [3:0] ptr_q;
  logic [4:0] cnt_q;
  logic [5:0] width;
  logic last_bit;
  logic addr_match;
  logic [23:0] in_sr_q;
  logic [23:0] in_next;
  logic [2:0] snap_q;
  logic [2:0] flags_q;
  logic status_done;
  logic snap_take;
  logic commit;
  logic fifo_in_ready;

  assign cmd_next = {cmd_sr_q[6:0], sdi_s};
  assign width = adcsp_pkg::reg_bits(ptr_q);
  assign last_bit = ({1'b0, cnt_q} == (width - 6'h01));
  assign addr_match = (cmd_next[1:0] == adcsp_pkg::DEV_CODE);
  assign snap_take = rise && (st_q == adcsp_pkg::ST_CMD) &&
                     (cnt_q == adcsp_pkg::ADDR_LAST_BIT) && addr_match;
  assign status_done = rise && (st_q == adcsp_pkg::ST_CMD) &&
                       (cnt_q == adcsp_pkg::CMD_LAST_BIT);
  assign in_next = {(cnt_q == 5'h00) ? 23'h00_0000 : in_sr_q[22:0], sdi_s};
  assign commit = rise && (st_q == adcsp_pkg::ST_WRITE) && last_bit;

  // Pointer step in the write loop; locations outside 0x1..0xD are never targets.
  function automatic logic [3:0] wr_next(input logic [3:0] p);
    logic [3:0] n;
    n = p + 4'h1;
    if ((p == adcsp_pkg::ADDR_WR_LAST) || !adcsp_pkg::is_writable(n)) begin
      n = adcsp_pkg::ADDR_WR_FIRST;
    end
    return n;
  endfunction : wr_next

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= adcsp_pkg::ST_IDLE;
      cmd_sr_q <= 8'h00;
      ctype_q <= adcsp_pkg::CT_FAST;
      ptr_q <= 4'h0;
      cnt_q <= 5'h00;
      in_sr_q <= 24'h00_0000;
    end else if (cs_b_s) begin
      st_q <= adcsp_pkg::ST_IDLE;
      cnt_q <= 5'h00;
    end else if (cs_fall) begin
      st_q <= adcsp_pkg::ST_CMD;
      cnt_q <= 5'h00;
    end else if (rise) begin
      unique case (st_q)
        adcsp_pkg::ST_CMD: begin
          cmd_sr_q <= cmd_next;
          cnt_q <= cnt_q + 5'h01;
          if ((cnt_q == adcsp_pkg::ADDR_LAST_BIT) && !addr_match) begin
            st_q <= adcsp_pkg::ST_FLOAT;
          end else if (cnt_q == adcsp_pkg::CMD_LAST_BIT) begin
            cnt_q <= 5'h00;
            ctype_q <= cmd_next[1:0];
            ptr_q <= cmd_next[5:2];
            if (cmd_next[0]) begin
              st_q <= adcsp_pkg::ST_READ;
            end else if ((cmd_next[1:0] == adcsp_pkg::CT_WRITE) &&
                         adcsp_pkg::is_writable(cmd_next[5:2])) begin
              st_q <= adcsp_pkg::ST_WRITE;
            end else begin
              st_q <= adcsp_pkg::ST_FLOAT;
            end
          end
        end
        adcsp_pkg::ST_WRITE: begin
          in_sr_q <= in_next;
          cnt_q <= cnt_q + 5'h01;
          if (last_bit) begin
            cnt_q <= 5'h00;
            ptr_q <= wr_next(ptr_q);
          end
        end
        adcsp_pkg::ST_READ: begin
          cnt_q <= cnt_q + 5'h01;
          if (last_bit) begin
            cnt_q <= 5'h00;
            if (ctype_q == adcsp_pkg::CT_IREAD) begin
              ptr_q <= ptr_q + 4'h1;
            end
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Status flags
  // ---------------------------------------------------------------------------
  // A new event in the clearing cycle survives, because the set term is ORed last.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      flags_q <= adcsp_pkg::FLAGS_RST;
      snap_q <= 3'h0;
    end else begin
      if (snap_take) begin
        snap_q <= flags_q;
      end
      flags_q <= (flags_q & ~(status_done ? snap_q : 3'h0)) |
                 {conv_valid, cfg_err_event, 1'b0};
    end
  end

  // ---------------------------------------------------------------------------
  // Conversion result double buffer
  // ---------------------------------------------------------------------------
  logic [15:0] result_q;
  logic [15:0] pend_q;
  logic pend_v_q;
  logic busy_q;
  logic busy_start;
  logic swapped_q;

  assign busy_start = rise && (st_q == adcsp_pkg::ST_READ) && (cnt_q == 5'h00) &&
                      (ptr_q == adcsp_pkg::ADDR_RESULT);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_q <= 1'b0;
    end else if (cs_b_s || (rise && last_bit)) begin
      busy_q <= 1'b0;
    end else if (busy_start) begin
      busy_q <= 1'b1;
    end
  end

  // A sample arriving mid-read waits in the second buffer until the shift ends.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      result_q <= adcsp_pkg::RESULT_RST;
      pend_q <= adcsp_pkg::RESULT_RST;
      pend_v_q <= 1'b0;
      swapped_q <= 1'b0;
    end else begin
      swapped_q <= 1'b0;
      if (busy_q || busy_start) begin
        if (conv_valid) begin
          pend_q <= conv_data;
          pend_v_q <= 1'b1;
        end
      end else if (conv_valid) begin
        result_q <= conv_data;
        pend_v_q <= 1'b0;
        swapped_q <= 1'b1;
      end else if (pend_v_q) begin
        result_q <= pend_q;
        pend_v_q <= 1'b0;
        swapped_q <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Output shifter
  // ---------------------------------------------------------------------------
  logic [31:0] out_sr_q;
  logic rose_q;
  logic load_pend_q;

  // MSB-aligned value of one register as it goes out on SDO.
  function automatic logic [31:0] aligned(input logic [3:0] a, input logic [15:0] res,
                                          input logic [15:0][31:0] img);
    logic [31:0] v;
    v = (a == adcsp_pkg::ADDR_RESULT) ? {16'h0000, res} : img[a];
    return v << (adcsp_pkg::WORD_BITS - adcsp_pkg::reg_bits(a));
  endfunction : aligned

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      out_sr_q <= adcsp_pkg::SHIFT_RST;
      rose_q <= 1'b0;
      load_pend_q <= 1'b0;
    end else if (cs_fall) begin
      out_sr_q <= {2'b00, adcsp_pkg::DEV_CODE, adcsp_pkg::DEV_CODE[0], 27'h000_0000};
      rose_q <= 1'b0;
      load_pend_q <= 1'b0;
    end else if (rise) begin
      rose_q <= 1'b1;
      if (snap_take) begin
        out_sr_q[27:25] <= flags_q;
      end
      if (status_done || ((st_q == adcsp_pkg::ST_READ) && last_bit)) begin
        load_pend_q <= 1'b1;
      end
      if ((st_q == adcsp_pkg::ST_READ) && (cnt_q == 5'h00)) begin
        out_sr_q <= aligned(ptr_q, result_q, reg_image);
      end
    end else if (fall && rose_q) begin
      rose_q <= 1'b0;
      load_pend_q <= 1'b0;
      if (load_pend_q) begin
        out_sr_q <= aligned(ptr_q, result_q, reg_image);
      end else begin
        out_sr_q <= {out_sr_q[30:0], 1'b0};
      end
    end else if (swapped_q && !sck_s && !rose_q && !load_pend_q &&
                 (st_q == adcsp_pkg::ST_READ) && (cnt_q == 5'h00) &&
                 (ptr_q == adcsp_pkg::ADDR_RESULT)) begin
      // Idle-low clock between results: show the fresh MSB when it lands.
      out_sr_q <= aligned(ptr_q, result_q, reg_image);
    end
    // With the clock idle high nothing reloads, so the previous LSB stays.
  end

  // ---------------------------------------------------------------------------
  // Pin drivers and status outputs
  // ---------------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sdo_out <= 1'b0;
      sdo_oe_b <= 1'b1;
    end else begin
      sdo_out <= out_sr_q[31];
      sdo_oe_b <= !((st_q == adcsp_pkg::ST_CMD) || (st_q == adcsp_pkg::ST_READ));
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      frame_active <= 1'b0;
      ptr_out <= 4'h0;
      flags_out <= adcsp_pkg::FLAGS_RST;
    end else begin
      frame_active <= !cs_b_s;
      ptr_out <= ptr_q;
      flags_out <= flags_q;
    end
  end

  // The serial master cannot be stalled, so a full FIFO drops the word and says so.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_overflow <= 1'b0;
    end else if (commit && !fifo_in_ready) begin
      wr_overflow <= 1'b1;
    end else if (cs_fall) begin
      wr_overflow <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Write FIFO
  // ---------------------------------------------------------------------------
  adcsp_fifo #(
    .WIDTH($bits(adcsp_pkg::adcsp_wr_word_t)),
    .DEPTH(adcsp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(core_clk),
    .rst_b(rst_b),
    .in_valid(commit),
    .in_ready(fifo_in_ready),
    .in_data({ptr_q, in_next}),
    .out_valid(wr_valid),
    .out_ready(wr_ready),
    .out_data(wr_word)
  );

endmodule : adcsp_core

/* rtl/adcsp_pkg.sv */
// Purpose: Shared constants and types for the converter's serial register-access engine.
// Assumes: One core clock; serial pins are sampled, never used as clocks.
// Notes:   Register widths and the device code are fixed here for all files.

package adcsp_pkg;

  // ---------------------------------------------------------------------------
  // Command decoding
  // ---------------------------------------------------------------------------
  // Hard-wired chip select code; the value is arbitrary.
  localparam logic [1:0] DEV_CODE = 2'b01;
  localparam logic [1:0] CT_FAST = 2'b00;
  localparam logic [1:0] CT_SREAD = 2'b01;
  localparam logic [1:0] CT_WRITE = 2'b10;
  localparam logic [1:0] CT_IREAD = 2'b11;
  localparam logic [4:0] CMD_LAST_BIT = 5'h07;
  localparam logic [4:0] ADDR_LAST_BIT = 5'h01;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [3:0] ADDR_RESULT = 4'h0;
  localparam logic [3:0] ADDR_WR_FIRST = 4'h1;
  localparam logic [3:0] ADDR_WR_LAST = 4'hD;
  localparam logic [5:0] WORD_BITS = 6'h20;
  localparam int FIFO_DEPTH = 16;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [2:0] FLAGS_RST = 3'h1;
  localparam logic [15:0] RESULT_RST = 16'h0000;
  localparam logic [31:0] SHIFT_RST = 32'h0000_0000;

  typedef struct packed {
    logic [3:0] addr;
    logic [23:0] data;
  } adcsp_wr_word_t;

  typedef struct packed {
    logic data_ready;
    logic cfg_err;
    logic power_on;
  } adcsp_flags_t;

  typedef enum {ST_IDLE, ST_CMD, ST_WRITE, ST_READ, ST_FLOAT} adcsp_state_t;

  // Number of bits in one access of each register.
  function automatic logic [5:0] reg_bits(input logic [3:0] addr);
    logic [5:0] w;
    w = 6'h08;
    unique case (addr)
      4'h0: w = 6'h10;
      4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC: w = 6'h18;
      4'hE, 4'hF: w = 6'h10;
      default: w = 6'h08;
    endcase
    return w;
  endfunction : reg_bits

  function automatic logic is_writable(input logic [3:0] addr);
    return (addr >= ADDR_WR_FIRST) && (addr <= ADDR_WR_LAST);
  endfunction : is_writable

endpackage : adcsp_pkg

/* rtl/adcsp_sync.sv */
// Purpose: Two-flop synchroniser for the serial pins.
// Assumes: Inputs are asynchronous to core_clk.
// Notes:   Only the second stage leaves this module.

`timescale 1ns/1ps

module adcsp_sync #(
  parameter int WIDTH = 3,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Data
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= RST_VAL;
      dout <= RST_VAL;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end

endmodule : adcsp_sync

/* rtl/adcsp_fifo.sv */
// Purpose: Small synchronous FIFO for committed register writes.
// Assumes: Single clock; push and pop may happen in the same cycle.
// Notes:   Pointers carry one extra bit so full and empty are exact.

`timescale 1ns/1ps

module adcsp_fifo #(
  parameter int WIDTH = 28,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_q;
  logic [AW:0] rd_ptr_q;
  logic push;
  logic pop;

  assign in_ready = !((wr_ptr_q[AW] != rd_ptr_q[AW]) && (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]));
  assign out_valid = (wr_ptr_q != rd_ptr_q);
  assign out_data = mem[rd_ptr_q[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
    end
  end

endmodule : adcsp_fifo

/* dv/adcsp_core_asserts.sv */
// Purpose: Port-level assertions for the serial register-access engine.
// Assumes: Bound into adcsp_core; one clock domain.
// Notes:   Pin-to-output figures include the two-flop pin synchroniser.
`timescale 1ns/1ps
module adcsp_core_asserts (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Observed ports
  input wire logic cs_b_pin,
  input wire logic sdo_out,
  input wire logic sdo_oe_b,
  input wire logic conv_valid,
  input wire logic cfg_err_event,
  input wire logic wr_valid,
  input wire logic wr_ready,
  input wire adcsp_pkg::adcsp_wr_word_t wr_word,
  input wire logic frame_active,
  input wire adcsp_pkg::adcsp_flags_t flags_out
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  sdo_idle_float_a: assert property (cs_b_pin [*5] |-> sdo_oe_b)
    else $error("SDO driven while deselected");
  frame_end_a: assert property ($rose(cs_b_pin) |-> ##[1:4] !frame_active)
    else $error("frame outlived chip select");
  lead_zero_a: assert property ($rose(frame_active) |-> ##[0:2] (!sdo_oe_b && !sdo_out))
    else $error("status lead bit not driven low");
  wr_addr_ok_a: assert property (wr_valid |-> (wr_word.addr >= 4'h1 && wr_word.addr <= 4'hD))
    else $error("write to read-only address");
  dr_flag_set_a: assert property (conv_valid |-> ##[1:2] flags_out.data_ready)
    else $error("data ready flag missed");
  crc_flag_set_a: assert property (cfg_err_event |-> ##[1:2] flags_out.cfg_err)
    else $error("checksum flag missed");
  por_no_rise_a: assert property (!$rose(flags_out.power_on))
    else $error("power-on flag set again");
  flag_clr_frame_a: assert property ($fell(flags_out.data_ready) |-> frame_active)
    else $error("flag cleared outside a frame");
  wr_hold_a: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_word))
    else $error("write word dropped while stalled");
endmodule : adcsp_core_asserts

bind adcsp_core adcsp_core_asserts chk_u (.core_clk(core_clk), .rst_b(rst_b),
  .cs_b_pin(cs_b_pin), .sdo_out(sdo_out), .sdo_oe_b(sdo_oe_b), .conv_valid(conv_valid),
  .cfg_err_event(cfg_err_event), .wr_valid(wr_valid), .wr_ready(wr_ready),
  .wr_word(wr_word), .frame_active(frame_active), .flags_out(flags_out));

/* dv/adcsp_host.sv */
// Purpose: Behavioural SPI master standing in for the host controller.
// Assumes: Modes 0,0 and 1,1; pins move only at falling core_clk edges.
// Notes:   half sets the SCK half period in core cycles; raise it for a slow host.
`timescale 1ns/1ps
module adcsp_host (
  // Clock
  input wire logic core_clk,
  // Serial pins
  output logic sck,
  output logic cs_b,
  output logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe_b
);
  logic mode11 = 1'b0;
  int half = 4;
  initial begin
    sck = 1'b0;
    cs_b = 1'b1;
    sdi = 1'b0;
  end
  task automatic hw();
    repeat (half) @(negedge core_clk);
  endtask : hw
  task automatic sel(input logic m11);
    mode11 = m11;
    sck = m11;
    hw();
    cs_b = 1'b0;
    hw();
  endtask : sel
  task automatic desel();
    hw();
    cs_b = 1'b1;
    // A released line must not keep its last level, so it is turned over.
    sdi = ~sdi;
    hw();
    hw();
  endtask : desel
  // MSB first; nf counts bits whose sample found SDO floating.
  task automatic xfer(input int n, input logic [31:0] tx, output logic [31:0] rx,
                      output int nf);
    rx = 32'h0000_0000;
    nf = 0;
    for (int i = n - 1; i >= 0; i--) begin
      sck = 1'b0;
      sdi = tx[i];
      hw();
      sck = 1'b1;
      rx[i] = sdo;
      nf += int'(sdo_oe_b);
      hw();
    end
    if (!mode11) begin
      sck = 1'b0;
    end
  endtask : xfer
endmodule : adcsp_host

/* dv/adc_spi_register_access_tb.sv */
// Purpose: Self-checking bench for the serial register-access engine.
// Assumes: 50 MHz core clock, SCK of 160 ns from the host model.
// Notes:   Reserved registers are always written with their default.
`timescale 1ns/1ps
module adc_spi_register_access_tb;
  localparam logic [1:0] DC = adcsp_pkg::DEV_CODE;
  localparam logic [31:0] RSV_DFLT = 32'h0000_0000;
  localparam int RDY_OUT_DLY = 6;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic sck, cs_b, sdi, sdo_out, sdo_oe_b, sdo_line;
  logic conv_valid = 1'b0;
  logic [15:0] conv_data = 16'h0000;
  logic cfg_err_event = 1'b0;
  logic [15:0][31:0] reg_image;
  logic wr_valid, frame_active, wr_overflow;
  logic wr_ready = 1'b0;
  adcsp_pkg::adcsp_wr_word_t wr_word;
  logic [3:0] ptr_out;
  adcsp_pkg::adcsp_flags_t flags_out;
  logic [31:0] rx;
  int nf;
  int n_errors = 0;
  int check_count = 0;
  always #10 core_clk = ~core_clk;
  assign sdo_line = sdo_oe_b ? ~sdo_out : sdo_out;
  adcsp_core dut_u (.core_clk(core_clk), .rst_b(rst_b), .sck_pin(sck), .cs_b_pin(cs_b),
    .sdi_pin(sdi), .sdo_out(sdo_out), .sdo_oe_b(sdo_oe_b), .conv_valid(conv_valid),
    .conv_data(conv_data), .cfg_err_event(cfg_err_event), .reg_image(reg_image),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_word(wr_word),
    .frame_active(frame_active), .ptr_out(ptr_out), .flags_out(flags_out),
    .wr_overflow(wr_overflow));
  adcsp_host host_u (.core_clk(core_clk), .sck(sck), .cs_b(cs_b), .sdi(sdi),
    .sdo(sdo_line), .sdo_oe_b(sdo_oe_b));
  function automatic logic [31:0] img(input logic [3:0] a);
    return {8{a}} ^ 32'h0123_4567;
  endfunction : img
  function automatic int wb(input logic [3:0] a);
    if (a == 4'h0 || a >= 4'hE) return 16;
    return (a >= 4'h7 && a <= 4'hC) ? 24 : 8;
  endfunction : wb
  function automatic logic [31:0] lo(input logic [31:0] v, input int w);
    return v & ((32'h0000_0001 << w) - 32'h0000_0001);
  endfunction : lo
  function automatic logic [31:0] cmd(input logic [3:0] a, input logic [1:0] t);
    return {24'h00_0000, DC, a, t};
  endfunction : cmd
  function automatic logic [31:0] stat(input logic [2:0] f);
    return {24'h00_0000, 2'b00, DC[1], DC[0], DC[0], f};
  endfunction : stat
  function automatic logic [31:0] pat(input logic [3:0] a);
    return (a == 4'hB || a == 4'hC) ? RSV_DFLT : lo(img(a), wb(a));
  endfunction : pat
  initial for (int i = 0; i < 16; i++) reg_image[i] = img(4'(i));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic final_report();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report
  task automatic pop(input logic [3:0] a, input logic [31:0] d);
    int t;
    t = 0;
    while (wr_valid !== 1'b1 && t < 200) begin
      @(negedge core_clk);
      t++;
    end
    if (t == 200) begin
      n_errors++;
      final_report();
    end
    chk("wr addr", 32'(a), 32'(wr_word.addr));
    chk("wr data", d, 32'(wr_word.data));
    wr_ready = 1'b1;
    @(negedge core_clk);
    wr_ready = 1'b0;
    @(negedge core_clk);
  endtask : pop
  task automatic conv(input logic [15:0] d);
    conv_data = d;
    conv_valid = 1'b1;
    @(negedge core_clk);
    conv_valid = 1'b0;
  endtask : conv
  task automatic t_write1();
    chk("reset flags", 32'h0000_0001, 32'(flags_out));
    host_u.sel(1'b0);
    host_u.xfer(8, cmd(4'h1, 2'b10), rx, nf);
    chk("status", stat(3'b001), rx);
    host_u.xfer(8, 32'h0000_00A5, rx, nf);
    chk("write float", 32'h0000_0008, 32'(nf));
    host_u.desel();
    chk("por clear", 32'h0000_0000, 32'(flags_out.power_on));
    chk("ptr", 32'h0000_0002, 32'(ptr_out));
    pop(4'h1, 32'h0000_00A5);
  endtask : t_write1
  task automatic t_fill();
    logic [3:0] a;
    a = 4'h1;
    host_u.sel(1'b0);
    host_u.xfer(8, cmd(4'h1, 2'b10), rx, nf);
    for (int k = 0; k < 17; k++) begin
      host_u.xfer(wb(a), pat(a), rx, nf);
      a = (a == 4'hD) ? 4'h1 : a + 4'h1;
    end
    host_u.desel();
    chk("overflow", 32'h0000_0001, 32'(wr_overflow));
    a = 4'h1;
    for (int k = 0; k < 16; k++) begin
      pop(a, pat(a));
      a = (a == 4'hD) ? 4'h1 : a + 4'h1;
    end
    chk("drained", 32'h0000_0000, 32'(wr_valid));
  endtask : t_fill
  task automatic t_refuse();
    host_u.sel(1'b0);
    host_u.xfer(8, cmd(4'h7, 2'b10), rx, nf);
    host_u.xfer(12, 32'h0000_0ABC, rx, nf);
    host_u.desel();
    repeat (20) @(negedge core_clk);
    chk("abort", 32'h0000_0000, 32'(wr_valid));
    host_u.sel(1'b0);
    host_u.xfer(8, cmd(4'h0, 2'b10), rx, nf);
    host_u.xfer(16, 32'h0000_1234, rx, nf);
    chk("ro float", 32'h0000_0010, 32'(nf));
    host_u.desel();
    chk("ro drop", 32'h0000_0000, 32'(wr_valid));
    host_u.sel(1'b0);
    host_u.xfer(8, {24'h00_0000, ~DC, 4'h1, 2'b11}, rx, nf);
    chk("nomatch", 32'h0000_0006, 32'(nf));
    host_u.xfer(8, 32'h0000_0000, rx, nf);
    chk("nomatch float", 32'h0000_0008, 32'(nf));
    host_u.desel();
  endtask : t_refuse
  task automatic t_read(input logic m);
    host_u.sel(m);
    host_u.xfer(8, cmd(4'hF, 2'b11), rx, nf);
    chk("status", stat(3'b000), rx);
    host_u.xfer(16, 32'h0000_0000, rx, nf);
    chk("rd F", lo(img(4'hF), 16), rx);
    host_u.xfer(16, 32'h0000_0000, rx, nf);
    chk("rd 0", 32'(adcsp_pkg::RESULT_RST), rx);
    host_u.xfer(8, 32'h0000_0000, rx, nf);
    chk("rd 1", lo(img(4'h1), 8), rx);
    host_u.desel();
    host_u.sel(m);
    host_u.xfer(8, cmd(4'h2, 2'b01), rx, nf);
    for (int k = 0; k < 2; k++) begin
      host_u.xfer(8, 32'h0000_0000, rx, nf);
      chk("static", lo(img(4'h2), 8), rx);
    end
    host_u.desel();
    chk("static ptr", 32'h0000_0002, 32'(ptr_out));
  endtask : t_read
  task automatic t_stream(input logic m);
    host_u.sel(m);
    host_u.xfer(8, cmd(4'h0, 2'b01), rx, nf);
    conv(16'hA5C3);
    repeat (RDY_OUT_DLY) @(negedge core_clk);
    fork
      host_u.xfer(16, 32'h0000_0000, rx, nf);
      begin
        repeat (40) @(negedge core_clk);
        conv(16'h3C5A);
      end
    join
    chk("res old", 32'h0000_A5C3, rx);
    repeat (8) @(negedge core_clk);
    chk("sdo rest", 32'(m), 32'(sdo_out));
    host_u.xfer(16, 32'h0000_0000, rx, nf);
    chk("res new", 32'h0000_3C5A, rx);
    host_u.desel();
    cfg_err_event = 1'b1;
    @(negedge core_clk);
    cfg_err_event = 1'b0;
    host_u.sel(m);
    host_u.xfer(8, cmd(4'h1, 2'b01), rx, nf);
    chk("status ev", stat(3'b110), rx);
    host_u.desel();
  endtask : t_stream
  initial begin
    repeat (100000) @(posedge core_clk);
    n_errors++;
    final_report();
  end
  initial begin
    repeat (4) @(negedge core_clk);
    rst_b = 1'b1;
    t_write1();
    t_fill();
    t_refuse();
    for (int m = 0; m < 2; m++) t_read(m[0]);
    for (int m = 0; m < 2; m++) t_stream(m[0]);
    final_report();
  end
endmodule : adc_spi_register_access_tb
